/* include/bsi_if.sv */
/*
 two-wire link between the sensor end and the host end.
 assumes a pull-up: each line is low when either party enables its driver.
*/
`timescale 1ns/1ps
interface bsi_if;
   logic scl_o_host;
   logic scl_oe_host;
   logic sda_o_host;
   logic sda_oe_host;
   logic sda_o_dev;
   logic sda_oe_dev;
   logic scl;
   logic sda;
   assign scl = ~(scl_oe_host & ~scl_o_host);
   assign sda = ~((sda_oe_host & ~sda_o_host) | (sda_oe_dev & ~sda_o_dev));
   modport dev (input scl, input sda, output sda_o_dev, output sda_oe_dev);
   modport host (input scl, input sda, output scl_o_host, output scl_oe_host,
      output sda_o_host, output sda_oe_host);
endinterface

/* include/bsi_pkg.sv */
/*
 shared constants for the barometric sensor i2c command port: target address,
 command codes, prom layout and timing counts.
 assumes a 100 mhz system clock on both ends.
*/
package bsi_pkg;
   localparam logic [5:0] BSI_ADDR_HI = 6'h3b;
   localparam logic [7:0] BSI_CMD_RESET = 8'h1e;
   localparam logic [7:0] BSI_CMD_ADC_READ = 8'h00;
   localparam logic [7:0] BSI_CMD_CONV_LO = 8'h40;
   localparam logic [7:0] BSI_CMD_CONV_HI = 8'h58;
   localparam logic [7:0] BSI_CMD_PROM_BASE = 8'ha0;
   localparam logic [7:0] BSI_CMD_PROM_MASK = 8'hf1;
   localparam int BSI_PROM_ADDR_LSB = 1;
   localparam int BSI_TEMP_SEL_BIT = 4;
   localparam int BSI_OSR_LSB = 1;
   localparam int BSI_PROM_WORDS = 8;
   localparam int BSI_CLK_MHZ = 100;
   // base conversion time at the lowest oversampling ratio, in microseconds
   localparam int BSI_CONV_BASE_US = 600;
   localparam int BSI_CONV_BASE_CYC = BSI_CONV_BASE_US * BSI_CLK_MHZ;
   // scl half period of the host, in nanoseconds
   localparam int BSI_SCL_HALF_NS = 1250;
   localparam int BSI_SCL_HALF_CYC = BSI_SCL_HALF_NS * BSI_CLK_MHZ / 1000;
   localparam int BSI_RECOVER_CLOCKS = 9;
endpackage

/* rtl/bsi_host.sv */
/*
 host end of the barometric sensor i2c command port: sends one message per
 request, either a command write or a read of 2 or 3 bytes, and a bus recovery.
 assumes the sensor end sits on the same link and scl is not stretched.
*/
`timescale 1ns/1ps
module bsi_host import bsi_pkg::*; #(
   parameter int HALF_CYC = BSI_SCL_HALF_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link
   bsi_if.host bus,
   // request
   input wire logic req_valid,
   input wire logic req_read,
   input wire logic req_recover,
   input wire logic [1:0] req_nbytes,
   input wire logic [7:0] req_cmd,
   input wire logic addr_select_pin,
   // answer
   output logic req_ready,
   output logic done,
   output logic nack,
   output logic [23:0] rdata
);
   typedef enum logic [2:0] {
      BSI_H_IDLE, BSI_H_START, BSI_H_BITS, BSI_H_STOP, BSI_H_STOP2
   } bsi_hstate_t;

   bsi_hstate_t state_q;
   logic [15:0] div_q;
   logic tick;
   logic phase_q;
   logic scl_q;
   logic sda_q;
   logic [5:0] bit_q;
   logic [5:0] nbits_q;
   logic [35:0] frame_q;
   logic [35:0] drive_q;
   logic [23:0] rx_q;
   logic nack_q;
   logic done_q;
   logic [2:0] sda_s_q;
   logic rec_q;

   assign tick = (div_q == 16'(HALF_CYC - 1));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= (tick || state_q == BSI_H_IDLE) ? 16'h0000 : div_q + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_s_q <= 3'h7;
      end else begin
         sda_s_q <= {sda_s_q[1:0], bus.sda};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= BSI_H_IDLE;
         phase_q <= 1'b0;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bit_q <= 6'h00;
         nbits_q <= 6'h00;
         frame_q <= 36'h0;
         drive_q <= 36'h0;
         rx_q <= 24'h000000;
         nack_q <= 1'b0;
         done_q <= 1'b0;
         rec_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         unique case (state_q)
            BSI_H_IDLE: if (req_valid) begin
               state_q <= BSI_H_START;
               rec_q <= req_recover;
               nack_q <= 1'b0;
               bit_q <= 6'h00;
               phase_q <= 1'b0;
               if (req_recover) begin
                  nbits_q <= 6'(BSI_RECOVER_CLOCKS);
                  frame_q <= {36{1'b1}};
                  drive_q <= 36'h0;
               end else if (req_read) begin
                  nbits_q <= (req_nbytes == 2'h3) ? 6'd36 : 6'd27;
                  // zeros in the acknowledge slots the host drives after each byte but the last
                  frame_q <= {BSI_ADDR_HI, ~addr_select_pin, 1'b1, 1'b1, 27'h7fbfdff};
                  drive_q <= {8'hff, 1'b0, 8'h00, 1'b1, 8'h00,
                     (req_nbytes == 2'h3) ? 1'b1 : 1'b0, 8'h00, 1'b0};
               end else begin
                  nbits_q <= 6'd18;
                  frame_q <= {BSI_ADDR_HI, ~addr_select_pin, 1'b0, 1'b1, req_cmd,
                     1'b1, 18'h0};
                  drive_q <= {8'hff, 1'b0, 8'hff, 1'b0, 18'h0};
               end
            end
            BSI_H_START: if (tick) begin
               if (rec_q) begin
                  state_q <= BSI_H_BITS;
                  scl_q <= 1'b0;
               end else if (!phase_q) begin
                  sda_q <= 1'b0;
                  phase_q <= 1'b1;
               end else begin
                  scl_q <= 1'b0;
                  phase_q <= 1'b0;
                  state_q <= BSI_H_BITS;
               end
            end
            BSI_H_BITS: if (tick) begin
               if (!scl_q) begin
                  sda_q <= drive_q[35] ? frame_q[35] : 1'b1;
                  scl_q <= 1'b1;
               end else begin
                  scl_q <= 1'b0;
                  if (!drive_q[35] && !rec_q) begin
                     if (bit_q == 6'd8 || bit_q == 6'd17) begin
                        nack_q <= nack_q | sda_s_q[2];
                     end else if (bit_q != nbits_q - 6'h01) begin
                        // the closing not-acknowledge slot is not data
                        rx_q <= {rx_q[22:0], sda_s_q[2]};
                     end
                  end
                  frame_q <= {frame_q[34:0], 1'b1};
                  drive_q <= {drive_q[34:0], 1'b0};
                  bit_q <= bit_q + 6'h01;
                  if (bit_q == nbits_q - 6'h01) begin
                     state_q <= BSI_H_STOP;
                  end
               end
            end
            BSI_H_STOP: if (tick) begin
               sda_q <= 1'b0;
               scl_q <= 1'b1;
               state_q <= BSI_H_STOP2;
            end
            BSI_H_STOP2: if (tick) begin
               sda_q <= 1'b1;
               done_q <= 1'b1;
               state_q <= BSI_H_IDLE;
            end
         endcase
      end
   end

   assign bus.scl_o_host = 1'b0;
   assign bus.scl_oe_host = ~scl_q;
   assign bus.sda_o_host = 1'b0;
   assign bus.sda_oe_host = ~sda_q;
   assign req_ready = (state_q == BSI_H_IDLE);
   assign done = done_q;
   assign nack = nack_q;
   assign rdata = rx_q;
endmodule

/* rtl/bsi_sensor.sv */
/*
 sensor end of the barometric sensor i2c command port: target state machine,
 command decode, conversion timer, result and prom return.
 assumes the host end drives scl; the analog sample arrives on a user port.
*/
// Behaviour
// - address 111011 plus inverted select pin
// - messages framed by start and stop
// - reset command accepted at any time
// - host recovers stuck line by clocks, reset
// - prom read is write then read
// - prom word returned high byte first
// - busy until conversion completes
// - adc read returns 24 result bits
// - acknowledge after every eight bits
// - conversion started by one write message
// - 128 bit prom holding 4 bit crc
// - word 0 maker, 1-5 coefficients
// - single byte command codes
// - adc read returns zero when invalid
// - word 6 coefficient, 7 serial and crc
`timescale 1ns/1ps
module bsi_sensor import bsi_pkg::*; #(
   parameter int CONV_BASE_CYC = BSI_CONV_BASE_CYC,
   parameter logic [127:0] PROM_IMAGE = 128'h0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // strap
   input wire logic addr_select_pin,
   // link
   bsi_if.dev bus,
   // analog front end
   input wire logic [23:0] raw_pressure_sample,
   input wire logic [23:0] raw_temperature_sample,
   output logic busy,
   output logic result_valid,
   output logic soft_reset
);
   typedef enum logic [2:0] {
      BSI_S_IDLE, BSI_S_ADDR, BSI_S_AACK, BSI_S_WR, BSI_S_WACK, BSI_S_RD, BSI_S_RACK,
      BSI_S_SKIP
   } bsi_dstate_t;

   bsi_dstate_t state_q;
   logic [2:0] scl_s_q;
   logic [2:0] sda_s_q;
   logic scl_f;
   logic sda_f;
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;
   logic [7:0] shift_q;
   logic [3:0] bitcnt_q;
   logic rw_q;
   logic [2:0] prom_addr_q;
   logic prom_mode_q;
   logic [23:0] result_q;
   logic result_ok_q;
   logic corrupt_q;
   logic temp_sel_q;
   logic [31:0] conv_cnt_q;
   logic [1:0] byte_idx_q;
   logic [23:0] tx_q;
   logic sda_oe_q;
   logic busy_q;
   logic soft_reset_q;
   logic [15:0] prom_word [BSI_PROM_WORDS];

   // words 0..7 of the calibration store, word 7 low nibble is the crc
   genvar gi;
   generate
      for (gi = 0; gi < BSI_PROM_WORDS; gi++) begin : g_prom
         assign prom_word[gi] = PROM_IMAGE[127 - 16*gi -: 16];
      end
   endgenerate

   // three-stage sampling of the pins, filtered on stages two and three
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[1:0], bus.scl};
         sda_s_q <= {sda_s_q[1:0], bus.sda};
         scl_prev_q <= scl_f;
         sda_prev_q <= sda_f;
      end
   end
   assign scl_f = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_prev_q;
   assign sda_f = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_prev_q;
   assign scl_rise = scl_f & ~scl_prev_q;
   assign scl_fall = ~scl_f & scl_prev_q;
   assign start_c = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
   assign stop_c = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

   // target protocol engine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= BSI_S_IDLE;
         shift_q <= 8'h00;
         bitcnt_q <= 4'h0;
         rw_q <= 1'b0;
         sda_oe_q <= 1'b0;
         byte_idx_q <= 2'h0;
      end else if (start_c) begin
         state_q <= BSI_S_ADDR;
         bitcnt_q <= 4'h0;
         sda_oe_q <= 1'b0;
      end else if (stop_c) begin
         state_q <= BSI_S_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         unique case (state_q)
            BSI_S_IDLE, BSI_S_SKIP: sda_oe_q <= 1'b0;
            BSI_S_ADDR, BSI_S_WR: begin
               if (scl_rise) begin
                  shift_q <= {shift_q[6:0], sda_f};
                  bitcnt_q <= bitcnt_q + 4'h1;
               end else if (scl_fall && bitcnt_q == 4'h8) begin
                  bitcnt_q <= 4'h0;
                  if (state_q == BSI_S_ADDR) begin
                     if (shift_q[7:1] == {BSI_ADDR_HI, ~addr_select_pin}) begin
                        rw_q <= shift_q[0];
                        sda_oe_q <= 1'b1;
                        state_q <= BSI_S_AACK;
                        byte_idx_q <= 2'h0;
                     end else begin
                        state_q <= BSI_S_SKIP;
                     end
                  end else begin
                     sda_oe_q <= 1'b1;
                     state_q <= BSI_S_WACK;
                  end
               end
            end
            BSI_S_AACK, BSI_S_WACK: begin
               if (scl_fall) begin
                  if (rw_q && state_q == BSI_S_AACK) begin
                     state_q <= BSI_S_RD;
                     sda_oe_q <= ~tx_q[23];
                     bitcnt_q <= 4'h1;
                  end else begin
                     sda_oe_q <= 1'b0;
                     state_q <= BSI_S_WR;
                  end
               end
            end
            BSI_S_RD: begin
               if (scl_fall) begin
                  if (bitcnt_q == 4'h8) begin
                     sda_oe_q <= 1'b0;
                     state_q <= BSI_S_RACK;
                     byte_idx_q <= byte_idx_q + 2'h1;
                  end else begin
                     sda_oe_q <= ~tx_q[23 - 8*byte_idx_q - bitcnt_q];
                     bitcnt_q <= bitcnt_q + 4'h1;
                  end
               end
            end
            BSI_S_RACK: begin
               if (scl_rise) begin
                  state_q <= sda_f ? BSI_S_SKIP : BSI_S_RACK;
               end else if (scl_fall) begin
                  state_q <= BSI_S_RD;
                  sda_oe_q <= ~tx_q[23 - 8*byte_idx_q];
                  bitcnt_q <= 4'h1;
               end
            end
         endcase
      end
   end

   // command decode, conversion timer and result store
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prom_mode_q <= 1'b0;
         prom_addr_q <= 3'h0;
         result_q <= 24'h000000;
         result_ok_q <= 1'b0;
         corrupt_q <= 1'b0;
         temp_sel_q <= 1'b0;
         conv_cnt_q <= 32'h0;
         busy_q <= 1'b0;
         soft_reset_q <= 1'b0;
         tx_q <= 24'h000000;
      end else begin
         soft_reset_q <= 1'b0;
         if (busy_q) begin
            if (conv_cnt_q <= 32'h1) begin
               busy_q <= 1'b0;
               result_ok_q <= ~corrupt_q;
               result_q <= corrupt_q ? 24'h000000 :
                  (temp_sel_q ? raw_temperature_sample : raw_pressure_sample);
            end else begin
               conv_cnt_q <= conv_cnt_q - 32'h1;
            end
         end
         if (state_q == BSI_S_WR && scl_fall && bitcnt_q == 4'h8) begin
            if (shift_q == BSI_CMD_RESET) begin
               busy_q <= 1'b0;
               result_ok_q <= 1'b0;
               corrupt_q <= 1'b0;
               prom_mode_q <= 1'b0;
               soft_reset_q <= 1'b1;
            end else if (shift_q == BSI_CMD_ADC_READ) begin
               prom_mode_q <= 1'b0;
               tx_q <= (result_ok_q && !busy_q) ? result_q : 24'h000000;
               result_ok_q <= 1'b0;
               if (busy_q) begin
                  corrupt_q <= 1'b1;
               end
            end else if ((shift_q & BSI_CMD_PROM_MASK) == BSI_CMD_PROM_BASE) begin
               prom_mode_q <= 1'b1;
               prom_addr_q <= shift_q[BSI_PROM_ADDR_LSB +: 3];
               tx_q <= {prom_word[shift_q[BSI_PROM_ADDR_LSB +: 3]], 8'h00};
            end else if (shift_q >= BSI_CMD_CONV_LO && shift_q <= BSI_CMD_CONV_HI &&
                         !shift_q[0]) begin
               prom_mode_q <= 1'b0;
               corrupt_q <= busy_q;
               busy_q <= 1'b1;
               result_ok_q <= 1'b0;
               temp_sel_q <= shift_q[BSI_TEMP_SEL_BIT];
               conv_cnt_q <= 32'(CONV_BASE_CYC) << shift_q[BSI_OSR_LSB +: 3];
            end
         end
      end
   end

   assign bus.sda_o_dev = 1'b0;
   assign bus.sda_oe_dev = sda_oe_q;
   assign busy = busy_q;
   assign result_valid = result_ok_q;
   assign soft_reset = soft_reset_q;
endmodule

/* testbench/baro_sensor_i2c_cmd_port_test.sv */
/*
 self-checking bench: sensor end and host end joined by one link.
 assumes the bench drives the host request port and the sensor samples.
*/
`timescale 1ns/1ps
module baro_sensor_i2c_cmd_port_test import bsi_pkg::*;;
   localparam int CONV = 50;
   localparam int HALF = 8;
   localparam logic [127:0] PROM = 128'h0a5c_1b2d_3e4f_5061_7283_94a5_b6c7_d8e9;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic dev_pin = 1'b0;
   logic host_pin = 1'b0;
   logic [23:0] p_samp = 24'h0;
   logic [23:0] t_samp = 24'h0;
   logic req_valid = 1'b0;
   logic req_read = 1'b0;
   logic req_recover = 1'b0;
   logic [1:0] req_nbytes = 2'h2;
   logic [7:0] req_cmd = 8'h00;
   logic busy, result_valid, soft_reset, req_ready, done, nack;
   logic [23:0] rdata;
   logic [31:0] seed = 32'd9257;
   int errors = 0;
   int compares = 0;
   int sr_cnt = 0;
   int busy_len = 0;
   int last_len = 0;

   bsi_if link ();
   bsi_sensor #(.CONV_BASE_CYC(CONV), .PROM_IMAGE(PROM)) bsi_sensor_inst (.clk(clk),
      .rst_n(rst_n), .addr_select_pin(dev_pin), .bus(link.dev), .raw_pressure_sample(p_samp),
      .raw_temperature_sample(t_samp), .busy(busy), .result_valid(result_valid),
      .soft_reset(soft_reset));
   bsi_host #(.HALF_CYC(HALF)) bsi_host_inst (.clk(clk), .rst_n(rst_n), .bus(link.host),
      .req_valid(req_valid), .req_read(req_read), .req_recover(req_recover),
      .req_nbytes(req_nbytes), .req_cmd(req_cmd), .addr_select_pin(host_pin),
      .req_ready(req_ready), .done(done), .nack(nack), .rdata(rdata));
   bsi_link_checker bsi_link_checker_inst (.clk(clk), .rst_n(rst_n),
      .scl_o_host(link.scl_o_host), .scl_oe_host(link.scl_oe_host),
      .sda_o_host(link.sda_o_host), .sda_oe_host(link.sda_oe_host),
      .sda_o_dev(link.sda_o_dev), .sda_oe_dev(link.sda_oe_dev), .scl(link.scl),
      .sda(link.sda), .addr_select_pin(dev_pin));

   initial begin
      forever #5 clk = ~clk;
   end

   // counts reset pulses and the length of each busy phase
   always @(posedge clk) begin
      if (soft_reset === 1'b1) sr_cnt++;
      if (busy === 1'b1) busy_len++;
      else if (busy_len != 0) begin
         last_len = busy_len;
         busy_len = 0;
      end
   end

   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      if (errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // one host request, held until taken, then wait for its completion
   task automatic xfer(input logic rd, input logic rec, input logic [1:0] nb,
      input logic [7:0] cmd);
      int n;
      logic taken;
      n = 0;
      taken = 1'b0;
      req_valid = 1'b1;
      req_read = rd;
      req_recover = rec;
      req_nbytes = nb;
      req_cmd = cmd;
      do begin
         @(posedge clk);
         n++;
         taken = (req_ready === 1'b1);
      end while (!taken && n < 50);
      #1;
      req_valid = 1'b0;
      req_recover = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 3000 || !taken) begin
         check("done wait", 24'h0, 24'h1);
         finish_test();
      end
   endtask

   task automatic send(input logic [7:0] c);
      xfer(1'b0, 1'b0, 2'h2, c);
      check("nack write", {23'h0, nack}, 24'h0);
   endtask

   task automatic fetch(input logic [1:0] nb, input logic [23:0] exp);
      xfer(1'b1, 1'b0, nb, 8'h00);
      check("nack read", {23'h0, nack}, 24'h0);
      check("rdata", (nb == 2'h2) ? {8'h00, rdata[15:0]} : rdata, exp);
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 2000) begin
         check("busy wait", 24'h1, 24'h0);
         finish_test();
      end
   endtask

   initial begin
      logic [15:0] prom_m [8];
      logic [31:0] r;
      logic [7:0] c;
      logic [23:0] res_m;
      int t, o, w, n0;
      for (w = 0; w < 8; w++) prom_m[w] = PROM[127 - 16 * w -: 16];
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      // every prom word, both address straps
      for (w = 0; w < 8; w++) begin
         r = xorshift();
         dev_pin = r[0];
         host_pin = r[0];
         send(BSI_CMD_PROM_BASE | 8'(w << BSI_PROM_ADDR_LSB));
         fetch(2'h2, {8'h00, prom_m[w]});
      end
      // conversion codes of ratios 0 to 4 for pressure and temperature, result read once then zero
      for (t = 0; t < 2; t++) begin
         for (o = 0; o < 5; o++) begin
            c = BSI_CMD_CONV_LO | 8'(t << BSI_TEMP_SEL_BIT) | 8'(o << BSI_OSR_LSB);
            r = xorshift();
            p_samp = r[23:0];
            r = xorshift();
            t_samp = r[23:0];
            res_m = (t == 1) ? t_samp : p_samp;
            send(c);
            check("busy", {23'h0, busy}, 24'h1);
            wait_idle();
            tick(1);
            p_samp = ~p_samp;
            t_samp = ~t_samp;
            check("busy span", 24'(last_len >= (CONV << o) && last_len <= (CONV << o) + 4),
               24'h1);
            check("valid", {23'h0, result_valid}, 24'h1);
            send(BSI_CMD_ADC_READ);
            fetch(2'h3, res_m);
            send(BSI_CMD_ADC_READ);
            fetch(2'h3, 24'h0);
         end
      end
      // read during conversion, then restart during conversion
      send(8'h48);
      send(BSI_CMD_ADC_READ);
      fetch(2'h3, 24'h0);
      wait_idle();
      send(BSI_CMD_ADC_READ);
      fetch(2'h3, 24'h0);
      // the first conversion must outlast the next write message
      send(8'h58);
      send(8'h52);
      wait_idle();
      send(BSI_CMD_ADC_READ);
      fetch(2'h3, 24'h0);
      // reset command in mid conversion
      send(8'h58);
      n0 = sr_cnt;
      send(BSI_CMD_RESET);
      tick(4);
      check("reset pulse", 24'(sr_cnt - n0), 24'h1);
      check("busy after reset", {23'h0, busy}, 24'h0);
      send(BSI_CMD_ADC_READ);
      fetch(2'h3, 24'h0);
      // foreign address is ignored
      host_pin = ~dev_pin;
      xfer(1'b0, 1'b0, 2'h2, 8'h48);
      check("nack foreign", {23'h0, nack}, 24'h1);
      check("busy foreign", {23'h0, busy}, 24'h0);
      host_pin = dev_pin;
      // bus recovery then reset, link usable again
      xfer(1'b0, 1'b1, 2'h2, 8'h00);
      send(BSI_CMD_RESET);
      send(BSI_CMD_PROM_BASE | 8'h0e);
      fetch(2'h2, {8'h00, prom_m[7]});
      // hard reset in mid conversion
      send(8'h48);
      tick(5);
      rst_n = 1'b0;
      tick(2);
      check("busy in reset", {23'h0, busy}, 24'h0);
      check("valid in reset", {23'h0, result_valid}, 24'h0);
      rst_n = 1'b1;
      send(BSI_CMD_ADC_READ);
      fetch(2'h3, 24'h0);
      finish_test();
   end
endmodule

/* testbench/bsi_link_checker.sv */
/*
 concurrent checks on the two-wire link between sensor end and host end.
 assumes plain wire levels from the link interface and a 100 mhz clock.
*/
`timescale 1ns/1ps
module bsi_link_checker import bsi_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // link
   input wire logic scl_o_host,
   input wire logic scl_oe_host,
   input wire logic sda_o_host,
   input wire logic sda_oe_host,
   input wire logic sda_o_dev,
   input wire logic sda_oe_dev,
   input wire logic scl,
   input wire logic sda,
   // strap of the sensor end
   input wire logic addr_select_pin
);
   logic scl_q, sda_q, in_msg_q, first_q, rd_q, match_q;
   logic [3:0] cnt_q;
   logic [7:0] byte_q;
   logic rise, start, stop;
   assign rise = scl && !scl_q;
   assign start = scl && scl_q && sda_q && !sda;
   assign stop = scl && scl_q && !sda_q && sda;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // bit position and kind of the message in flight
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_msg_q <= 1'b0;
         first_q <= 1'b0;
         rd_q <= 1'b0;
         match_q <= 1'b0;
         cnt_q <= 4'h0;
         byte_q <= 8'h00;
      end else if (start) begin
         in_msg_q <= 1'b1;
         first_q <= 1'b1;
         cnt_q <= 4'h0;
      end else if (stop) begin
         in_msg_q <= 1'b0;
      end else if (rise) begin
         byte_q <= {byte_q[6:0], sda};
         cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
         if (cnt_q == 4'h8 && first_q) begin
            first_q <= 1'b0;
            rd_q <= byte_q[0];
            match_q <= byte_q[7:1] == {BSI_ADDR_HI, ~addr_select_pin};
         end
      end
   end

   AST_DEV_OPEN_DRAIN: assert property (sda_oe_dev |-> !sda_o_dev)
      else $error("sensor drives sda high");
   AST_DEV_STEADY_SCL_HIGH: assert property (scl && $past(scl) |-> $stable(sda_oe_dev))
      else $error("sensor changed sda while scl high");
   AST_DEV_IDLE_QUIET: assert property (!in_msg_q |-> !sda_oe_dev)
      else $error("sensor drives sda outside a message");
   AST_ADDR_ACK: assert property (rise && in_msg_q && first_q && cnt_q == 4'h8 |->
      sda_oe_dev == (byte_q[7:1] == {BSI_ADDR_HI, ~addr_select_pin}))
      else $error("address acknowledge wrong");
   AST_WRITE_BITS_QUIET: assert property (rise && in_msg_q && cnt_q != 4'h8 &&
      (first_q || !rd_q) |-> !sda_oe_dev)
      else $error("sensor drives a host data bit");
   AST_CMD_ACK: assert property (rise && in_msg_q && cnt_q == 4'h8 && !first_q &&
      !rd_q && match_q |-> sda_oe_dev)
      else $error("command byte not acknowledged");
   AST_READ_ACK_SLOT_FREE: assert property (rise && in_msg_q && cnt_q == 4'h8 &&
      !first_q && rd_q |-> !sda_oe_dev)
      else $error("sensor drives the host acknowledge slot");
   AST_SCL_HIGH_MIN: assert property ($rose(scl) |=> scl[*5])
      else $error("scl high phase too short");
endmodule
